// File: include/opcode_decoder_regs.vh
// Opcode, operation and field constants for the transfer/arithmetic decoder
`ifndef OPCODE_DECODER_REGS_VH
`define OPCODE_DECODER_REGS_VH

// Operation identities handed to the execution unit
`define OP_NONE 5'h00
`define OP_COPY_TO_SEG 5'h01
`define OP_COPY_FROM_SEG 5'h02
`define OP_TABLE_LOOKUP_BYTE 5'h03
`define OP_EFFECTIVE_ADDRESS_LOAD 5'h04
`define OP_FAR_POINTER_LOAD_DATASEG 5'h05
`define OP_FAR_POINTER_LOAD_EXTRASEG 5'h06
`define OP_FLAGS_TO_HIGH_ACC 5'h07
`define OP_HIGH_ACC_TO_FLAGS 5'h08
`define OP_SUM 5'h09
`define OP_SUM_WITH_CARRY 5'h0a
`define OP_DIFFERENCE 5'h0b
`define OP_DIFFERENCE_WITH_BORROW 5'h0c
`define OP_ASCII_FIX_AFTER_SUM 5'h0d
`define OP_PACKED_BCD_FIX_AFTER_SUM 5'h0e
`define OP_ASCII_FIX_AFTER_DIFFERENCE 5'h0f
`define OP_PACKED_BCD_FIX_AFTER_DIFFERENCE 5'h10
`define OP_UNSIGNED_PRODUCT 5'h11
`define OP_SIGNED_PRODUCT 5'h12
`define OP_UNSIGNED_QUOTIENT 5'h13
`define OP_SIGNED_QUOTIENT 5'h14
`define OP_ASCII_FIX_AFTER_PRODUCT 5'h15
`define OP_ASCII_FIX_BEFORE_QUOTIENT 5'h16
`define OP_BYTE_TO_WORD_SIGN_EXTEND 5'h17
`define OP_WORD_TO_DOUBLEWORD_SIGN_EXTEND 5'h18

// Operand forms
`define FORM_RM 2'h0
`define FORM_IMM_RM 2'h1
`define FORM_IMM_ACC 2'h2
`define FORM_IMPLIED 2'h3

// Fixed first bytes, and the fixed second byte of the two adjust pairs
`define BYTE_COPY_TO_SEG 8'h8e
`define BYTE_COPY_FROM_SEG 8'h8c
`define BYTE_TABLE_LOOKUP 8'hd7
`define BYTE_EA_LOAD 8'h8d
`define BYTE_FAR_DATASEG 8'hc5
`define BYTE_FAR_EXTRASEG 8'hc4
`define BYTE_FLAGS_TO_HIGH 8'h9f
`define BYTE_HIGH_TO_FLAGS 8'h9e
`define BYTE_ASCII_SUM 8'h37
`define BYTE_PACKED_SUM 8'h27
`define BYTE_ASCII_DIFF 8'h3f
`define BYTE_PACKED_DIFF 8'h2f
`define BYTE_ASCII_PRODUCT 8'hd4
`define BYTE_ASCII_QUOTIENT 8'hd5
`define BYTE_ADJUST_BASE 8'h0a
`define BYTE_BYTE_TO_WORD 8'h98
`define BYTE_WORD_TO_DWORD 8'h99

// Extension field codes of the immediate group 100000sw
`define EXT_SUM 3'h0
`define EXT_SUM_CARRY 3'h2
`define EXT_DIFF_BORROW 3'h3
`define EXT_DIFF 3'h5
// Extension field codes of the group 1111011w
`define EXT_UPRODUCT 3'h4
`define EXT_SPRODUCT 3'h5
`define EXT_UQUOTIENT 3'h6
`define EXT_SQUOTIENT 3'h7

// Addressing byte field positions
`define MOD_HI 7
`define MOD_LO 6
`define REG_HI 5
`define REG_LO 3
`define RM_HI 2
`define RM_LO 0
`define SEG_ZERO_BIT 5
`define MOD_DIRECT 2'h0
`define MOD_DISP8 2'h1
`define MOD_DISP16 2'h2
`define RM_DIRECT_ADDR 3'h6

`endif

// File: src/operand_length_calc.v
// Counts displacement and immediate bytes that follow the opcode or addressing byte
`timescale 1ns/10ps
`include "opcode_decoder_regs.vh"

module operand_length_calc (
  input wire [1:0] form,
  input wire wBit,
  input wire sBit,
  input wire [7:0] modrm,
  output reg [1:0] dispCount,
  output reg [1:0] immCount
);

  wire [1:0] modF = modrm[`MOD_HI:`MOD_LO];
  wire [2:0] rmF = modrm[`RM_HI:`RM_LO];

  always @* begin
    dispCount = 2'h0;
    immCount = 2'h0;
    if (form == `FORM_RM || form == `FORM_IMM_RM) begin
      if (modF == `MOD_DISP8)
        dispCount = 2'h1;
      else if (modF == `MOD_DISP16)
        dispCount = 2'h2;
      else if (modF == `MOD_DIRECT && rmF == `RM_DIRECT_ADDR)
        dispCount = 2'h2;
    end
    // One byte when sign and width are both set, else width decides
    if (form == `FORM_IMM_RM)
      immCount = (wBit && !sBit) ? 2'h2 : 2'h1;
    else if (form == `FORM_IMM_ACC)
      immCount = wBit ? 2'h2 : 2'h1;
  end

endmodule

// File: src/opcode_decoder_xfer_arith.v
// Decoder for the data-transfer and arithmetic instruction groups
// How it works
// - 10001110 with addressing reg bit5 clear copies r/m into segment.
// - 10001100 with addressing reg bit5 clear copies segment into r/m.
// - Byte 11010111 is table_lookup_byte, no addressing byte follows.
// - 10001101 plus addressing byte is effective_address_load.
// - 11000101 plus addressing byte is far_pointer_load_dataseg.
// - 11000100 plus addressing byte is far_pointer_load_extraseg.
// - Byte 10011111 is flags_to_high_acc.
// - Byte 10011110 is high_acc_to_flags.
// - sum_op from 000000dw, 100000sw ext 000, 0000010w.
// - sum_with_carry_op from 000100dw, 100000sw ext 010, 0001010w.
// - difference_op from 001010dw, 100000sw ext 101, 0010110w.
// - Byte 00110111 is ascii_fix_after_sum.
// - Byte 00100111 is packed_bcd_fix_after_sum.
// - Byte 00111111 is ascii_fix_after_difference.
// - Byte 00101111 is packed_bcd_fix_after_difference.
// - 1111011w with extension 100 is unsigned_product_op.
// - 1111011w with extension 101 is signed_product_op.
// - 1111011w with extension 110 is unsigned_quotient_op.
// - 1111011w with extension 111 is signed_quotient_op.
// - Bytes 11010100 then 00001010 are ascii_fix_after_product.
// - Bytes 11010101 then 00001010 are ascii_fix_before_quotient.
// - 10011000 is byte_to_word, 10011001 word_to_doubleword sign extend.
`timescale 1ns/10ps
`include "opcode_decoder_regs.vh"

module opcode_decoder_xfer_arith (
  input wire clk,
  input wire rst_n,
  input wire qValid,
  input wire [7:0] qByte,
  output wire qReady,
  output wire opValid,
  input wire opReady,
  output reg [4:0] opId,
  output reg [1:0] opForm,
  output reg opWide,
  output reg opRegDest,
  output reg opSignExt,
  output reg [7:0] opFirstByte,
  output reg [7:0] opModrm,
  output reg [15:0] opDisp,
  output reg [15:0] opImm
);

  localparam S_FIRST = 3'h0;
  localparam S_SECOND = 3'h1;
  localparam S_DISP = 3'h2;
  localparam S_IMM = 3'h3;
  localparam S_OUT = 3'h4;

  // First-byte decode: {op, form, needSecond, wide, regDest}
  function [9:0] decodeFirst;
    input [7:0] b;
    begin
      casez (b)
        `BYTE_COPY_TO_SEG:
          decodeFirst = {`OP_COPY_TO_SEG, `FORM_RM, 3'b111};
        `BYTE_COPY_FROM_SEG:
          decodeFirst = {`OP_COPY_FROM_SEG, `FORM_RM, 3'b110};
        `BYTE_TABLE_LOOKUP:
          decodeFirst = {`OP_TABLE_LOOKUP_BYTE, `FORM_IMPLIED,
                         3'b000};
        `BYTE_EA_LOAD:
          decodeFirst = {`OP_EFFECTIVE_ADDRESS_LOAD, `FORM_RM,
                         3'b111};
        `BYTE_FAR_DATASEG:
          decodeFirst = {`OP_FAR_POINTER_LOAD_DATASEG, `FORM_RM,
                         3'b111};
        `BYTE_FAR_EXTRASEG:
          decodeFirst = {`OP_FAR_POINTER_LOAD_EXTRASEG, `FORM_RM,
                         3'b111};
        `BYTE_FLAGS_TO_HIGH:
          decodeFirst = {`OP_FLAGS_TO_HIGH_ACC, `FORM_IMPLIED,
                         3'b000};
        `BYTE_HIGH_TO_FLAGS:
          decodeFirst = {`OP_HIGH_ACC_TO_FLAGS, `FORM_IMPLIED,
                         3'b000};
        8'b0000_00??:
          decodeFirst = {`OP_SUM, `FORM_RM, 1'b1, b[0], b[1]};
        8'b0001_00??:
          decodeFirst = {`OP_SUM_WITH_CARRY, `FORM_RM, 1'b1, b[0],
                         b[1]};
        8'b0010_10??:
          decodeFirst = {`OP_DIFFERENCE, `FORM_RM, 1'b1, b[0],
                         b[1]};
        8'b0001_10??:
          decodeFirst = {`OP_DIFFERENCE_WITH_BORROW, `FORM_RM, 1'b1, b[0],
                         b[1]};
        8'b1000_00??:
          decodeFirst = {`OP_NONE, `FORM_IMM_RM, 1'b1, b[0], 1'b0};
        8'b0000_010?:
          decodeFirst = {`OP_SUM, `FORM_IMM_ACC, 1'b0, b[0],
                         1'b0};
        8'b0001_010?:
          decodeFirst = {`OP_SUM_WITH_CARRY, `FORM_IMM_ACC, 1'b0, b[0],
                         1'b0};
        8'b0010_110?:
          decodeFirst = {`OP_DIFFERENCE, `FORM_IMM_ACC, 1'b0, b[0],
                         1'b0};
        8'b0001_110?:
          decodeFirst = {`OP_DIFFERENCE_WITH_BORROW, `FORM_IMM_ACC, 1'b0,
                         b[0], 1'b0};
        `BYTE_ASCII_SUM:
          decodeFirst = {`OP_ASCII_FIX_AFTER_SUM, `FORM_IMPLIED,
                         3'b000};
        `BYTE_PACKED_SUM:
          decodeFirst = {`OP_PACKED_BCD_FIX_AFTER_SUM, `FORM_IMPLIED,
                         3'b000};
        `BYTE_ASCII_DIFF:
          decodeFirst = {`OP_ASCII_FIX_AFTER_DIFFERENCE, `FORM_IMPLIED,
                         3'b000};
        `BYTE_PACKED_DIFF:
          decodeFirst = {`OP_PACKED_BCD_FIX_AFTER_DIFFERENCE, `FORM_IMPLIED,
                         3'b000};
        8'b1111_011?:
          decodeFirst = {`OP_NONE, `FORM_RM, 1'b1, b[0], 1'b0};
        `BYTE_ASCII_PRODUCT:
          decodeFirst = {`OP_NONE, `FORM_IMPLIED, 3'b100};
        `BYTE_ASCII_QUOTIENT:
          decodeFirst = {`OP_NONE, `FORM_IMPLIED, 3'b100};
        `BYTE_BYTE_TO_WORD:
          decodeFirst = {`OP_BYTE_TO_WORD_SIGN_EXTEND, `FORM_IMPLIED,
                         3'b000};
        `BYTE_WORD_TO_DWORD:
          decodeFirst = {`OP_WORD_TO_DOUBLEWORD_SIGN_EXTEND, `FORM_IMPLIED,
                         3'b010};
        default:
          decodeFirst = {`OP_NONE, `FORM_IMPLIED, 3'b000};
      endcase
    end
  endfunction

  // Final operation once the second byte is known
  function [4:0] resolveOp;
    input [7:0] first;
    input [7:0] second;
    input [4:0] baseOp;
    reg [2:0] ext;
    begin
      ext = second[`REG_HI:`REG_LO];
      resolveOp = baseOp;
      casez (first)
        8'b1000_00??: begin
          case (ext)
            `EXT_SUM: resolveOp = `OP_SUM;
            `EXT_SUM_CARRY: resolveOp = `OP_SUM_WITH_CARRY;
            `EXT_DIFF: resolveOp = `OP_DIFFERENCE;
            `EXT_DIFF_BORROW: resolveOp = `OP_DIFFERENCE_WITH_BORROW;
            default: resolveOp = `OP_NONE;
          endcase
        end
        8'b1111_011?: begin
          case (ext)
            `EXT_UPRODUCT: resolveOp = `OP_UNSIGNED_PRODUCT;
            `EXT_SPRODUCT: resolveOp = `OP_SIGNED_PRODUCT;
            `EXT_UQUOTIENT: resolveOp = `OP_UNSIGNED_QUOTIENT;
            `EXT_SQUOTIENT: resolveOp = `OP_SIGNED_QUOTIENT;
            default: resolveOp = `OP_NONE;
          endcase
        end
        `BYTE_COPY_TO_SEG, `BYTE_COPY_FROM_SEG: begin
          // Segment selector must carry a leading zero
          if (second[`SEG_ZERO_BIT])
            resolveOp = `OP_NONE;
        end
        `BYTE_ASCII_PRODUCT: begin
          resolveOp = (second == `BYTE_ADJUST_BASE) ?
                      `OP_ASCII_FIX_AFTER_PRODUCT : `OP_NONE;
        end
        `BYTE_ASCII_QUOTIENT: begin
          resolveOp = (second == `BYTE_ADJUST_BASE) ?
                      `OP_ASCII_FIX_BEFORE_QUOTIENT : `OP_NONE;
        end
        default: resolveOp = baseOp;
      endcase
    end
  endfunction

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] dispLeft_reg;
  reg [1:0] immLeft_reg;
  reg hiByte_reg;

  wire take = qValid && qReady;
  wire [7:0] curFirst = (state_reg == S_FIRST) ? qByte : opFirstByte;
  wire [9:0] firstDec = decodeFirst(curFirst);
  wire [4:0] secondOp = resolveOp(opFirstByte, qByte, opId);
  wire [1:0] dispCount;
  wire [1:0] immCount;

  operand_length_calc lengthCalc (
    .form(firstDec[4:3]),
    .wBit(curFirst[0]),
    .sBit(curFirst[1]),
    .modrm(qByte),
    .dispCount(dispCount),
    .immCount(immCount)
  );

  assign qReady = (state_reg != S_OUT);
  assign opValid = (state_reg == S_OUT);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_FIRST: begin
        if (take) begin
          if (firstDec[2])
            state_next = S_SECOND;
          else if (firstDec[4:3] == `FORM_IMM_ACC)
            state_next = S_IMM;
          else
            state_next = S_OUT;
        end
      end
      S_SECOND: begin
        if (take) begin
          if (secondOp == `OP_NONE)
            state_next = S_OUT;
          else if (dispCount != 2'h0)
            state_next = S_DISP;
          else if (immCount != 2'h0)
            state_next = S_IMM;
          else
            state_next = S_OUT;
        end
      end
      S_DISP: begin
        if (take && dispLeft_reg == 2'h1)
          state_next = (immLeft_reg != 2'h0) ? S_IMM : S_OUT;
      end
      S_IMM: begin
        if (take && immLeft_reg == 2'h1)
          state_next = S_OUT;
      end
      S_OUT: begin
        if (opReady)
          state_next = S_FIRST;
      end
      default: state_next = S_FIRST;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= S_FIRST;
      dispLeft_reg <= 2'h0;
      immLeft_reg <= 2'h0;
      hiByte_reg <= 1'b0;
      opId <= `OP_NONE;
      opForm <= `FORM_IMPLIED;
      opWide <= 1'b0;
      opRegDest <= 1'b0;
      opSignExt <= 1'b0;
      opFirstByte <= 8'h00;
      opModrm <= 8'h00;
      opDisp <= 16'h0000;
      opImm <= 16'h0000;
    end else begin
      state_reg <= state_next;
      case (state_reg)
        S_FIRST: begin
          if (take) begin
            opFirstByte <= qByte;
            opId <= firstDec[9:5];
            opForm <= firstDec[4:3];
            opWide <= firstDec[1];
            opRegDest <= firstDec[0];
            opSignExt <= (firstDec[4:3] == `FORM_IMM_RM) &&
                         qByte[1] && qByte[0];
            opModrm <= 8'h00;
            opDisp <= 16'h0000;
            opImm <= 16'h0000;
            hiByte_reg <= 1'b0;
            dispLeft_reg <= 2'h0;
            immLeft_reg <= immCount;
          end
        end
        S_SECOND: begin
          if (take) begin
            opModrm <= qByte;
            opId <= secondOp;
            dispLeft_reg <= dispCount;
            immLeft_reg <= immCount;
          end
        end
        S_DISP: begin
          if (take) begin
            if (hiByte_reg) begin
              opDisp[15:8] <= qByte;
            end else begin
              opDisp[7:0] <= qByte;
              // Short displacement is signed
              opDisp[15:8] <= {8{qByte[7]}};
            end
            hiByte_reg <= (dispLeft_reg == 2'h1) ? 1'b0 : 1'b1;
            dispLeft_reg <= dispLeft_reg - 2'h1;
          end
        end
        S_IMM: begin
          if (take) begin
            if (hiByte_reg) begin
              opImm[15:8] <= qByte;
            end else begin
              opImm[7:0] <= qByte;
              opImm[15:8] <= {8{opSignExt & qByte[7]}};
            end
            hiByte_reg <= (immLeft_reg == 2'h1) ? 1'b0 : 1'b1;
            immLeft_reg <= immLeft_reg - 2'h1;
          end
        end
        default: begin
          hiByte_reg <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: test/opcode_decoder_xfer_arith_props.sv
// Concurrent checks on decoded operations against their opening bytes
`timescale 1ns/10ps
`include "opcode_decoder_regs.vh"
module opcode_decoder_xfer_arith_chk (
  input wire clk,
  input wire rst_n,
  input wire qValid,
  input wire [7:0] qByte,
  input wire qReady,
  input wire opValid,
  input wire opReady,
  input wire [4:0] opId,
  input wire [1:0] opForm,
  input wire opWide,
  input wire opRegDest,
  input wire opSignExt,
  input wire [7:0] opFirstByte,
  input wire [7:0] opModrm,
  input wire [15:0] opDisp,
  input wire [15:0] opImm
);
  reg atFirst_reg;
  wire take = qValid && qReady;
  wire start = atFirst_reg && take;
  // Tracks whether the next byte taken opens an instruction
  always @(posedge clk) begin
    if (!rst_n)
      atFirst_reg <= 1'h1;
    else if (opValid && opReady)
      atFirst_reg <= 1'h1;
    else if (take)
      atFirst_reg <= 1'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_SEG_COPY: assert property (start && qByte == 8'h8e ##1 take &&
    qByte[7:6] == 2'h3 && !qByte[5] |=> opValid &&
    opId == `OP_COPY_TO_SEG && opWide && opRegDest)
    else $error("segment copy misdecoded");
  AST_TABLE_LOOKUP: assert property (start && qByte == 8'hd7 |=>
    opValid &&
    opId == `OP_TABLE_LOOKUP_BYTE && opForm == `FORM_IMPLIED)
    else $error("table lookup misdecoded");
  AST_FLAG_BYTE: assert property (start && qByte[7:1] == 7'h4f |=>
    opValid && opId == ($past(qByte[0]) ? `OP_FLAGS_TO_HIGH_ACC :
    `OP_HIGH_ACC_TO_FLAGS))
    else $error("flag byte transfer misdecoded");
  AST_ACC_SUM: assert property (start && qByte == 8'h04 ##1 take |=>
    opValid && opId == `OP_SUM && opForm == `FORM_IMM_ACC &&
    opImm == {8'h00, $past(qByte)})
    else $error("byte accumulator sum misdecoded");
  AST_BCD: assert property (start && qByte == 8'h27 |=> opValid &&
    opId == `OP_PACKED_BCD_FIX_AFTER_SUM)
    else $error("packed sum fix misdecoded");
  AST_ADJ_PRODUCT: assert property (start && qByte == 8'hd4 ##1
    take && qByte == 8'h0a |=> opValid &&
    opId == `OP_ASCII_FIX_AFTER_PRODUCT)
    else $error("product fix misdecoded");
  AST_UPRODUCT: assert property (opValid && opFirstByte[7:1] == 7'h7b &&
    opModrm[5:3] == 3'h4 |-> opId == `OP_UNSIGNED_PRODUCT &&
    opWide == opFirstByte[0])
    else $error("unsigned product misdecoded");
  AST_WIDTH: assert property (opValid && opId == `OP_SUM &&
    opForm == `FORM_RM |-> opWide == opFirstByte[0] &&
    opRegDest == opFirstByte[1])
    else $error("width or direction bit ignored");
  AST_SIGN_EXT: assert property (opValid && opSignExt |->
    opFirstByte[1:0] == 2'h3 && opImm[15:8] == {8{opImm[7]}})
    else $error("immediate sign extension wrong");
endmodule
bind opcode_decoder_xfer_arith opcode_decoder_xfer_arith_chk i_chk (
  .clk(clk), .rst_n(rst_n), .qValid(qValid), .qByte(qByte),
  .qReady(qReady), .opValid(opValid), .opReady(opReady), .opId(opId),
  .opForm(opForm), .opWide(opWide), .opRegDest(opRegDest),
  .opSignExt(opSignExt), .opFirstByte(opFirstByte), .opModrm(opModrm),
  .opDisp(opDisp), .opImm(opImm));

// File: test/byte_queue_model.sv
// Behavioural instruction byte queue feeding the decoder
`timescale 1ns/10ps
module byte_queue_model (
  input wire clk,
  input wire rst_n,
  input wire qReady,
  output reg qValid,
  output reg [7:0] qByte
);
  reg [7:0] mem [0:255];
  int head = 0;
  int tail = 0;
  bit slow = 0;
  bit ph = 0;
  bit took = 0;
  initial begin
    qValid = 1'h0;
    qByte = 8'h00;
  end
  task push(input [7:0] b);
    mem[tail] = b;
    tail++;
  endtask
  always @(posedge clk) begin
    took <= qValid && qReady;
    if (qValid && qReady)
      head <= head + 1;
  end
  // An offer not yet taken is held; slow mode leaves gaps after takes
  always @(negedge clk) begin
    ph <= ~ph;
    if (rst_n && head < tail && ((qValid && !took) || !(slow && ph))) begin
      qValid <= 1'h1;
      qByte <= mem[head];
    end else begin
      qValid <= 1'h0;
      qByte <= ~qByte;
    end
  end
endmodule

// File: test/opcode_decoder_xfer_arith_tb.sv
// Self-checking bench for the transfer and arithmetic decoder
`timescale 1ns/10ps
`include "opcode_decoder_regs.vh"
module opcode_decoder_xfer_arith_tb;
  localparam [41:0] MA = {42{1'h1}};
  localparam [41:0] MI = 42'h3f8_0000_0000;
  localparam [41:0] MW = 42'h3e4_0000_0000;
  localparam [41:0] MD = 42'h3e0_0000_0000;
  reg clk = 1'h0;
  reg rst_n = 1'h0;
  reg opReady = 1'h0;
  wire qValid, qReady, opValid, opWide, opRegDest, opSignExt;
  wire [7:0] qByte, opFirstByte, opModrm;
  wire [4:0] opId;
  wire [1:0] opForm;
  wire [15:0] opDisp, opImm;
  integer errTotal = 0, samplesChecked = 0, cyc = 0, lft = 0;
  byte_queue_model i_q (.clk(clk), .rst_n(rst_n), .qReady(qReady),
    .qValid(qValid), .qByte(qByte));
  opcode_decoder_xfer_arith i_dut (.clk(clk), .rst_n(rst_n),
    .qValid(qValid), .qByte(qByte), .qReady(qReady), .opValid(opValid),
    .opReady(opReady), .opId(opId), .opForm(opForm), .opWide(opWide),
    .opRegDest(opRegDest), .opSignExt(opSignExt),
    .opFirstByte(opFirstByte), .opModrm(opModrm), .opDisp(opDisp),
    .opImm(opImm));
  initial begin
    forever #2 clk = ~clk;
  end
  task results;
    if (errTotal == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errTotal++;
      results;
    end
  end
  task chk(input string n, input [41:0] e, input [41:0] g);
    samplesChecked++;
    if (e !== g) begin
      errTotal++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  // Feeds n bytes, holds the result two cycles, then accepts it
  task dec(input [47:0] b, input int n, input [41:0] m, input [41:0] e);
    int k;
    @(posedge clk);
    #1;
    for (k = 0; k < n; k++)
      i_q.push(b[47-8*k -: 8]);
    k = 0;
    while (opValid !== 1'h1 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("opValid", 1, opValid);
    chk("op", e & m, {opId, opForm, opWide, opRegDest, opSignExt,
      opDisp, opImm} & m);
    chk("first", b[47:40], opFirstByte);
    chk("left", lft, i_q.tail - i_q.head);
    // Drop unconsumed bytes by pulling the tail back; head has one driver
    i_q.tail = i_q.head;
    repeat (2) @(negedge clk);
    opReady = 1'h1;
    @(negedge clk);
    opReady = 1'h0;
    chk("opValid", 0, opValid);
  endtask
  task imp(input [15:0] b, input int n, input [4:0] id);
    dec({b, 32'h0}, n, MI, {id, `FORM_IMPLIED, 35'h0});
  endtask
  task t_transfer;
    dec(48'h8ed8_0000_0000, 2, MA,
      {`OP_COPY_TO_SEG, `FORM_RM, 3'h6, 32'h0});
    dec(48'h8c06_3412_0000, 4, MA,
      {`OP_COPY_FROM_SEG, `FORM_RM, 3'h4, 32'h1234_0000});
    imp(16'hd700, 1, `OP_TABLE_LOOKUP_BYTE);
    dec(48'h8d87_0080_0000, 4, MA,
      {`OP_EFFECTIVE_ADDRESS_LOAD, `FORM_RM, 3'h6, 32'h8000_0000});
    dec(48'hc51e_0001_0000, 4, MA,
      {`OP_FAR_POINTER_LOAD_DATASEG, `FORM_RM, 3'h6, 32'h0100_0000});
    dec(48'hc43f_0000_0000, 2, MA,
      {`OP_FAR_POINTER_LOAD_EXTRASEG, `FORM_RM, 3'h6, 32'h0});
    imp(16'h9f00, 1, `OP_FLAGS_TO_HIGH_ACC);
    imp(16'h9e00, 1, `OP_HIGH_ACC_TO_FLAGS);
  endtask
  task t_arith;
    dec(48'h01d8_0000_0000, 2, MA,
      {`OP_SUM, `FORM_RM, 3'h4, 32'h0});
    dec(48'h8306_1020_ff00, 5, MA,
      {`OP_SUM, `FORM_IMM_RM, 3'h5, 32'h2010_ffff});
    dec(48'h0434_0000_0000, 2, MA,
      {`OP_SUM, `FORM_IMM_ACC, 3'h0, 32'h0000_0034});
    dec(48'h82c0_8000_0000, 3, MA,
      {`OP_SUM, `FORM_IMM_RM, 3'h0, 32'h0000_0080});
    dec(48'h1307_0000_0000, 2, MA,
      {`OP_SUM_WITH_CARRY, `FORM_RM, 3'h6, 32'h0});
    dec(48'h80d1_0500_0000, 3, MA,
      {`OP_SUM_WITH_CARRY, `FORM_IMM_RM, 3'h0, 32'h0000_0005});
    dec(48'h147f_0000_0000, 2, MA,
      {`OP_SUM_WITH_CARRY, `FORM_IMM_ACC, 3'h0, 32'h0000_007f});
    dec(48'h18c0_0000_0000, 2, MA,
      {`OP_DIFFERENCE_WITH_BORROW, `FORM_RM, 3'h0, 32'h0});
    dec(48'h83d8_ff00_0000, 3, MA,
      {`OP_DIFFERENCE_WITH_BORROW, `FORM_IMM_RM, 3'h5, 32'h0000_ffff});
    i_q.slow = 1;
    dec(48'h284f_f000_0000, 3, MA,
      {`OP_DIFFERENCE, `FORM_RM, 3'h0, 32'hfff0_0000});
    dec(48'h81ee_3412_0000, 4, MA,
      {`OP_DIFFERENCE, `FORM_IMM_RM, 3'h4, 32'h0000_1234});
    dec(48'h2d80_ff00_0000, 3, MA,
      {`OP_DIFFERENCE, `FORM_IMM_ACC, 3'h4, 32'h0000_ff80});
    i_q.slow = 0;
  endtask
  task t_adjust;
    imp(16'h3700, 1, `OP_ASCII_FIX_AFTER_SUM);
    imp(16'h2700, 1, `OP_PACKED_BCD_FIX_AFTER_SUM);
    imp(16'h3f00, 1, `OP_ASCII_FIX_AFTER_DIFFERENCE);
    imp(16'h2f00, 1, `OP_PACKED_BCD_FIX_AFTER_DIFFERENCE);
    imp(16'hd40a, 2, `OP_ASCII_FIX_AFTER_PRODUCT);
    imp(16'hd50a, 2, `OP_ASCII_FIX_BEFORE_QUOTIENT);
    imp(16'h9800, 1, `OP_BYTE_TO_WORD_SIGN_EXTEND);
    imp(16'h9900, 1, `OP_WORD_TO_DOUBLEWORD_SIGN_EXTEND);
  endtask
  task t_muldiv;
    dec(48'hf6e0_0000_0000, 2, MW, {`OP_UNSIGNED_PRODUCT, 37'h0});
    dec(48'hf7ee_0000_0000, 2, MW,
      {`OP_SIGNED_PRODUCT, 37'h4_0000_0000});
    dec(48'hf6f3_0000_0000, 2, MW, {`OP_UNSIGNED_QUOTIENT, 37'h0});
    dec(48'hf738_0000_0000, 2, MW,
      {`OP_SIGNED_QUOTIENT, 37'h4_0000_0000});
  endtask
  // Bytes after a refused addressing byte must stay in the queue
  task t_refuse;
    lft = 1;
    dec(48'h8008_5500_0000, 3, MD, {`OP_NONE, 37'h0});
    dec(48'hf6d0_5500_0000, 3, MD, {`OP_NONE, 37'h0});
    dec(48'h8ee0_5500_0000, 3, MD, {`OP_NONE, 37'h0});
    dec(48'hd40b_5500_0000, 3, MD, {`OP_NONE, 37'h0});
    lft = 0;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    chk("reset", {1'h1, 1'h0, `FORM_IMPLIED}, {qReady, opValid, opForm});
    t_transfer;
    t_arith;
    t_adjust;
    t_muldiv;
    t_refuse;
    results;
  end
endmodule
